// ==== logic/program_space_data_access.sv ====
// table access, visibility window and self-programming front end
`timescale 1ns/1ps
module program_space_data_access (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic op_valid_i,
	input program_access_pkg::access_kind_t kind_i,
	input wire logic byte_mode_i,
	input wire logic [15:0] ea_i,
	input wire logic [15:0] wdata_i,
	input wire logic [7:0] table_page_i,
	input wire logic [7:0] visibility_page_i,
	input wire logic [15:0] core_control_i,
	input wire logic is_move_i,
	input wire logic in_repeat_i,
	input wire logic repeat_edge_i,
	output logic op_ready_o,
	output logic op_done_o,
	output logic stall_o,
	output logic data_space_o,
	output logic [15:0] rdata_o,
	output logic visibility_active_o,
	output logic pm_rd_o,
	output logic [23:0] pm_addr_o,
	output logic config_space_o,
	input wire logic [23:0] pm_rdata_i,
	input wire logic key_wr_i,
	input wire logic [7:0] key_data_i,
	input wire logic wr_start_i,
	input wire logic write_enable_i,
	input wire logic erase_i,
	input wire logic [3:0] nvm_op_i,
	input wire logic err_clr_i,
	output logic wr_busy_o,
	output logic wr_error_o,
	output logic array_start_o,
	output program_access_pkg::array_cmd_t array_cmd_o,
	output logic [23:0] array_addr_o,
	input wire logic array_done_i,
	input wire logic [5:0] array_buf_idx_i,
	output logic [23:0] array_buf_data_o
);
	typedef enum logic [2:0] {st_idle, st_fetch, st_fetch2, st_wait, st_bufwr, st_finish} state_t;
	typedef enum logic [1:0] {key_locked, key_first, key_open} key_state_t;

	state_t state_r, state_nxt;
	program_access_pkg::access_kind_t kind_r, kind_nxt;
	logic byte_r, byte_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic [23:0] addr_r, addr_nxt;
	logic [1:0] extra_r, extra_nxt;
	logic vis_r, vis_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic data_space_r, data_space_nxt;
	logic take, vis_hit, table_busy;

	key_state_t key_r, key_nxt;
	logic busy_r, busy_nxt;
	logic err_r, err_nxt;
	logic start_r, start_nxt;
	program_access_pkg::array_cmd_t cmd_r, cmd_nxt;
	logic [23:0] wbase_r, wbase_nxt;
	logic [23:0] aaddr_r, aaddr_nxt;
	program_access_pkg::array_cmd_t req_cmd;

	logic buf_wr;
	logic [1:0] buf_lo_be;
	logic buf_hi_en;
	logic [23:0] buf_data;

	// result formatting for table reads
	function automatic logic [15:0] fmt_read(input logic [23:0] w, input logic high,
			input logic bmode, input logic bsel);
		logic [15:0] r;
		r = 16'h0000;
		if (!high && !bmode) begin
			r = w[15:0];
		end else if (!high) begin
			r = {8'h00, bsel ? w[15:8] : w[7:0]};
		end else if (!bmode) begin
			r = {8'h00, w[23:16]};
		end else begin
			r = {8'h00, bsel ? 8'h00 : w[23:16]};
		end
		return r;
	endfunction : fmt_read

	function automatic logic [1:0] vis_extra(input logic mv, input logic rep, input logic edg);
		logic [1:0] e;
		e = mv ? program_access_pkg::EXTRA_MOVE : program_access_pkg::EXTRA_OTHER;
		if (rep) begin
			e = edg ? program_access_pkg::EXTRA_REPEAT_EDGE : program_access_pkg::EXTRA_REPEAT_MID;
		end
		return e;
	endfunction : vis_extra

	function automatic logic is_table(input program_access_pkg::access_kind_t k);
		return k != program_access_pkg::kind_data_read;
	endfunction : is_table

	assign take = op_valid_i && (state_r == st_idle);
	assign table_busy = (state_r != st_idle) && is_table(kind_r);
	assign visibility_active_o = core_control_i[program_access_pkg::VIS_ENABLE_BIT] && !table_busy;
	assign vis_hit = visibility_active_o && ea_i[program_access_pkg::VIS_EA_BIT];
	assign op_ready_o = (state_r == st_idle);
	assign op_done_o = (state_r == st_finish);
	assign stall_o = (state_r != st_idle) && (state_r != st_finish);
	assign pm_rd_o = (state_r == st_fetch) || (state_r == st_fetch2);
	assign pm_addr_o = {addr_r[23:1], 1'b0};
	assign config_space_o = !vis_r && addr_r[program_access_pkg::CFG_SPACE_BIT + 16];
	assign rdata_o = rdata_r;
	assign data_space_o = data_space_r;

	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		byte_nxt = byte_r;
		wdata_nxt = wdata_r;
		addr_nxt = addr_r;
		extra_nxt = extra_r;
		vis_nxt = vis_r;
		rdata_nxt = rdata_r;
		data_space_nxt = 1'b0;
		case (state_r)
			st_idle: begin
				if (take) begin
					kind_nxt = kind_i;
					byte_nxt = byte_mode_i;
					wdata_nxt = wdata_i;
					vis_nxt = 1'b0;
					addr_nxt = {table_page_i, ea_i};
					extra_nxt = vis_extra(is_move_i, in_repeat_i, repeat_edge_i);
					if (is_table(kind_i)) begin
						state_nxt = (kind_i == program_access_pkg::kind_table_read_low ||
							kind_i == program_access_pkg::kind_table_read_high) ? st_fetch : st_bufwr;
					end else if (vis_hit) begin
						vis_nxt = 1'b1;
						addr_nxt = {1'b0, visibility_page_i, ea_i[14:0]};
						state_nxt = st_fetch;
					end else begin
						data_space_nxt = 1'b1;
						state_nxt = st_finish;
					end
				end
			end
			st_fetch: begin
				if (vis_r) begin
					rdata_nxt = pm_rdata_i[15:0];
					state_nxt = (extra_r == 2'h0) ? st_finish : st_fetch2;
				end else begin
					rdata_nxt = fmt_read(pm_rdata_i, kind_r == program_access_pkg::kind_table_read_high,
						byte_r, addr_r[0]);
					state_nxt = st_finish;
				end
			end
			st_fetch2: begin
				rdata_nxt = pm_rdata_i[15:0];
				state_nxt = (extra_r == program_access_pkg::EXTRA_OTHER) ? st_wait : st_finish;
			end
			st_wait: state_nxt = st_finish;
			st_bufwr: state_nxt = st_finish;
			st_finish: state_nxt = st_idle;
			default: state_nxt = st_idle;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= st_idle;
			kind_r <= program_access_pkg::kind_data_read;
			byte_r <= 1'b0;
			wdata_r <= program_access_pkg::RDATA_RESET;
			addr_r <= program_access_pkg::ADDR_RESET;
			extra_r <= 2'h0;
			vis_r <= 1'b0;
			rdata_r <= program_access_pkg::RDATA_RESET;
			data_space_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			byte_r <= byte_nxt;
			wdata_r <= wdata_nxt;
			addr_r <= addr_nxt;
			extra_r <= extra_nxt;
			vis_r <= vis_nxt;
			rdata_r <= rdata_nxt;
			data_space_r <= data_space_nxt;
		end
	end

	// buffer lanes: low ops to bits 15..0, high ops to 23..16
	always_comb begin
		buf_wr = (state_r == st_bufwr);
		buf_lo_be = 2'b00;
		buf_hi_en = 1'b0;
		buf_data = {wdata_r[7:0], wdata_r};
		if (kind_r == program_access_pkg::kind_table_write_low) begin
			buf_lo_be = !byte_r ? 2'b11 : (addr_r[0] ? 2'b10 : 2'b01);
			if (byte_r) begin
				buf_data[15:0] = {wdata_r[7:0], wdata_r[7:0]};
			end
		end else if (kind_r == program_access_pkg::kind_table_write_high) begin
			buf_hi_en = !byte_r || !addr_r[0];
		end
	end

	row_holding_buffer u_buffer (
		.clk_i(clk_i),
		.wr_en_i(buf_wr),
		.wr_idx_i(addr_r[6:1]),
		.wr_lo_be_i(buf_lo_be),
		.wr_hi_en_i(buf_hi_en),
		.wr_data_i(buf_data),
		.rd_idx_i(array_buf_idx_i),
		.rd_data_o(array_buf_data_o)
	);

	always_comb begin
		req_cmd = program_access_pkg::cmd_none;
		if (erase_i && nvm_op_i == program_access_pkg::OP_PAGE_ERASE) begin
			req_cmd = program_access_pkg::cmd_page_erase;
		end else if (!erase_i && nvm_op_i == program_access_pkg::OP_ROW_PROGRAM) begin
			req_cmd = program_access_pkg::cmd_row_program;
		end else if (!erase_i && nvm_op_i == program_access_pkg::OP_WORD_PROGRAM) begin
			req_cmd = program_access_pkg::cmd_word_program;
		end
	end

	always_comb begin
		key_nxt = key_r;
		busy_nxt = busy_r;
		err_nxt = err_r && !err_clr_i;
		start_nxt = 1'b0;
		cmd_nxt = cmd_r;
		wbase_nxt = buf_wr ? addr_r : wbase_r;
		aaddr_nxt = aaddr_r;
		if (key_wr_i) begin
			if (key_data_i == program_access_pkg::KEY_FIRST) begin
				key_nxt = key_first;
			end else if (key_data_i == program_access_pkg::KEY_SECOND && key_r == key_first) begin
				key_nxt = key_open;
			end else begin
				key_nxt = key_locked;
			end
		end else if (key_r == key_first && (wr_start_i || take)) begin
			key_nxt = key_locked;
		end
		if (busy_r && array_done_i) begin
			busy_nxt = 1'b0;
		end
		if (wr_start_i && !busy_r) begin
			key_nxt = key_locked;
			if (key_r == key_open && write_enable_i && req_cmd != program_access_pkg::cmd_none) begin
				busy_nxt = 1'b1;
				start_nxt = 1'b1;
				cmd_nxt = req_cmd;
				case (req_cmd)
					program_access_pkg::cmd_row_program:
						aaddr_nxt = wbase_r & program_access_pkg::ROW_ALIGN_MASK;
					program_access_pkg::cmd_page_erase:
						aaddr_nxt = wbase_r & program_access_pkg::PAGE_ALIGN_MASK;
					default: aaddr_nxt = {wbase_r[23:1], 1'b0};
				endcase
			end else begin
				err_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			key_r <= key_locked;
			busy_r <= 1'b0;
			err_r <= 1'b0;
			start_r <= 1'b0;
			cmd_r <= program_access_pkg::cmd_none;
			wbase_r <= program_access_pkg::ADDR_RESET;
			aaddr_r <= program_access_pkg::ADDR_RESET;
		end else begin
			key_r <= key_nxt;
			busy_r <= busy_nxt;
			err_r <= err_nxt;
			start_r <= start_nxt;
			cmd_r <= cmd_nxt;
			wbase_r <= wbase_nxt;
			aaddr_r <= aaddr_nxt;
		end
	end

	assign wr_busy_o = busy_r;
	assign wr_error_o = err_r;
	assign array_start_o = start_r;
	assign array_cmd_o = cmd_r;
	assign array_addr_o = aaddr_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_vis_take;
		take && kind_i == program_access_pkg::kind_data_read && vis_hit;
	endsequence
	sequence s_fetch_low_word;
		state_r == st_fetch && !vis_r && kind_r == program_access_pkg::kind_table_read_low && !byte_r;
	endsequence

	property p_low_word;
		s_fetch_low_word |=> rdata_o == $past(pm_rdata_i[15:0]);
	endproperty
	a_low_word: assert property (p_low_word) else $error("low word read wrong");
	property p_low_byte;
		state_r == st_fetch && kind_r == program_access_pkg::kind_table_read_low && byte_r
			|=> rdata_o == {8'h00, $past(addr_r[0]) ? $past(pm_rdata_i[15:8]) : $past(pm_rdata_i[7:0])};
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("low byte read wrong");
	property p_high_word;
		state_r == st_fetch && kind_r == program_access_pkg::kind_table_read_high && !byte_r
			|=> rdata_o == {8'h00, $past(pm_rdata_i[23:16])};
	endproperty
	a_high_word: assert property (p_high_word) else $error("high word read wrong");
	property p_phantom;
		state_r == st_fetch && kind_r == program_access_pkg::kind_table_read_high && byte_r && addr_r[0]
			|=> rdata_o == 16'h0000;
	endproperty
	a_phantom: assert property (p_phantom) else $error("phantom byte not zero");
	property p_table_addr;
		take && is_table(kind_i) |=> pm_addr_o == {$past(table_page_i), $past(ea_i[15:1]), 1'b0};
	endproperty
	a_table_addr: assert property (p_table_addr) else $error("table address wrong");
	property p_no_redirect;
		take && kind_i == program_access_pkg::kind_data_read && !vis_hit |=> data_space_o && op_done_o;
	endproperty
	a_no_redirect: assert property (p_no_redirect) else $error("data access redirected");
	property p_vis_move;
		s_vis_take and is_move_i && !in_repeat_i |=> !op_done_o [*2] ##1 op_done_o;
	endproperty
	a_vis_move: assert property (p_vis_move) else $error("move window timing wrong");
	property p_vis_mid_repeat;
		s_vis_take and in_repeat_i && !repeat_edge_i |=> !op_done_o ##1 op_done_o;
	endproperty
	a_vis_mid_repeat: assert property (p_vis_mid_repeat) else $error("repeat window timing wrong");
	property p_table_write;
		take && (kind_i == program_access_pkg::kind_table_write_low ||
			kind_i == program_access_pkg::kind_table_write_high) |=> buf_wr ##1 op_done_o;
	endproperty
	a_table_write: assert property (p_table_write) else $error("table write timing wrong");
	property p_suspend;
		table_busy |-> !visibility_active_o;
	endproperty
	a_suspend: assert property (p_suspend) else $error("window live in table op");
	property p_refuse;
		wr_start_i && !busy_r && key_r != key_open |=> wr_error_o && !wr_busy_o && !array_start_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("locked start accepted");
	property p_self_clear;
		busy_r && array_done_i |=> !wr_busy_o;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("busy not cleared");
endmodule : program_space_data_access

// ==== logic/program_access_pkg.sv ====
// constants and types shared by the program space access block
package program_access_pkg;
	localparam int PROG_AW = 24;
	localparam int DATA_W = 16;
	localparam int PAGE_W = 8;
	localparam int ROW_WORDS = 64;
	localparam int ROW_BYTES = 192;
	localparam int PAGE_ROWS = 8;
	localparam int PAGE_WORDS = 512;
	localparam int PAGE_BYTES = 1536;
	localparam int ROW_IDX_W = 6;
	localparam int WORD_STEP = 2;
	localparam logic [23:0] ROW_ALIGN_MASK = 24'hFFFF80;
	localparam logic [23:0] PAGE_ALIGN_MASK = 24'hFFFC00;
	localparam int CFG_SPACE_BIT = 7;
	localparam int VIS_ENABLE_BIT = 2;
	localparam int VIS_EA_BIT = 15;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam int TBL_WRITE_CYCLES = 2;
	localparam logic [1:0] EXTRA_MOVE = 2'h1;
	localparam logic [1:0] EXTRA_OTHER = 2'h2;
	localparam logic [1:0] EXTRA_REPEAT_EDGE = 2'h2;
	localparam logic [1:0] EXTRA_REPEAT_MID = 2'h0;
	localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;
	localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
	localparam logic [3:0] OP_WORD_PROGRAM = 4'h3;
	localparam logic [15:0] RDATA_RESET = 16'h0000;
	localparam logic [23:0] ADDR_RESET = 24'h000000;

	typedef enum logic [2:0] {
		kind_data_read,
		kind_table_read_low,
		kind_table_read_high,
		kind_table_write_low,
		kind_table_write_high
	} access_kind_t;

	typedef enum logic [1:0] {
		cmd_none,
		cmd_row_program,
		cmd_page_erase,
		cmd_word_program
	} array_cmd_t;
endpackage : program_access_pkg

// ==== logic/row_holding_buffer.sv ====
// 64-instruction row holding buffer written by table writes
`timescale 1ns/1ps
module row_holding_buffer (
	input wire logic clk_i,
	input wire logic wr_en_i,
	input wire logic [5:0] wr_idx_i,
	input wire logic [1:0] wr_lo_be_i,
	input wire logic wr_hi_en_i,
	input wire logic [23:0] wr_data_i,
	input wire logic [5:0] rd_idx_i,
	output logic [23:0] rd_data_o
);
	logic [23:0] mem [0:program_access_pkg::ROW_WORDS-1];
	logic [23:0] rd_data_nxt;

	always_comb begin
		rd_data_nxt = mem[rd_idx_i];
	end

	// byte lanes let byte-mode table writes touch one lane only
	always_ff @(posedge clk_i) begin
		if (wr_en_i && wr_lo_be_i[0]) begin
			mem[wr_idx_i][7:0] <= wr_data_i[7:0];
		end
		if (wr_en_i && wr_lo_be_i[1]) begin
			mem[wr_idx_i][15:8] <= wr_data_i[15:8];
		end
		if (wr_en_i && wr_hi_en_i) begin
			mem[wr_idx_i][23:16] <= wr_data_i[23:16];
		end
		rd_data_o <= rd_data_nxt;
	end
endmodule : row_holding_buffer

// ==== test/program_memory_model.sv ====
// program memory and flash array stand-in on the far side
`timescale 1ns/1ps
module program_memory_model #(
	parameter int DONE_DELAY = 6
) (
	input wire logic clk_i,
	input wire logic pm_rd_i,
	input wire logic [23:0] pm_addr_i,
	output logic [23:0] pm_rdata_o,
	input wire logic array_start_i,
	output logic array_done_o
);
	logic [23:0] last_r = 24'h000000;
	int cnt_r = 0;

	// addresses with bit 22 set carry an all-ones top byte, so the word decodes as a no-op
	function automatic logic [23:0] word_at(input logic [23:0] a);
		return {a[22] ? 8'hFF : (a[23:16] ^ a[8:1]), a[15:0] ^ 16'h5A3C};
	endfunction : word_at

	// outside a fetch the bus flips every cycle
	assign pm_rdata_o = pm_rd_i ? word_at(pm_addr_i) : ~last_r;

	always @(posedge clk_i) begin
		last_r <= pm_rdata_o;
	end

	// self-timed array, done pulse some cycles after start
	always @(posedge clk_i) begin
		array_done_o <= (cnt_r == 1);
		if (array_start_i) begin
			cnt_r <= DONE_DELAY;
		end else if (cnt_r > 0) begin
			cnt_r <= cnt_r - 1;
		end
	end
endmodule : program_memory_model

// ==== test/program_space_data_access_bench.sv ====
// self-checking bench for the program space access block
`timescale 1ns/1ps
module program_space_data_access_bench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic op_valid_i = 1'b0, byte_mode_i = 1'b0;
	program_access_pkg::access_kind_t kind_i = program_access_pkg::kind_data_read;
	logic [15:0] ea_i = 16'h0000, wdata_i = 16'h0000, core_control_i = 16'h0000;
	logic [7:0] table_page_i = 8'h00, visibility_page_i = 8'h00, key_data_i = 8'h00;
	logic is_move_i = 1'b0, in_repeat_i = 1'b0, repeat_edge_i = 1'b0;
	logic key_wr_i = 1'b0, wr_start_i = 1'b0, write_enable_i = 1'b0, erase_i = 1'b0, err_clr_i = 1'b0;
	logic [3:0] nvm_op_i = 4'h0;
	logic [5:0] array_buf_idx_i = 6'h00;
	logic op_ready_o, op_done_o, stall_o, data_space_o, visibility_active_o, pm_rd_o, config_space_o;
	logic wr_busy_o, wr_error_o, array_start_o, array_done_i;
	logic [15:0] rdata_o;
	logic [23:0] pm_addr_o, pm_rdata_i, array_addr_o, array_buf_data_o;
	program_access_pkg::array_cmd_t array_cmd_o;
	int errors = 0;
	int compares = 0;

	program_space_data_access i_dut (
		.clk_i, .rst_n_i, .op_valid_i, .kind_i, .byte_mode_i, .ea_i, .wdata_i, .table_page_i,
		.visibility_page_i, .core_control_i, .is_move_i, .in_repeat_i, .repeat_edge_i, .op_ready_o,
		.op_done_o, .stall_o, .data_space_o, .rdata_o, .visibility_active_o, .pm_rd_o, .pm_addr_o,
		.config_space_o, .pm_rdata_i, .key_wr_i, .key_data_i, .wr_start_i, .write_enable_i, .erase_i,
		.nvm_op_i, .err_clr_i, .wr_busy_o, .wr_error_o, .array_start_o, .array_cmd_o, .array_addr_o,
		.array_done_i, .array_buf_idx_i, .array_buf_data_o
	);

	program_memory_model #(.DONE_DELAY(6)) i_mem (
		.clk_i(clk_i), .pm_rd_i(pm_rd_o), .pm_addr_i(pm_addr_o), .pm_rdata_o(pm_rdata_i),
		.array_start_i(array_start_o), .array_done_o(array_done_i)
	);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_sim();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick

	// one core request, n counts cycles from the taking edge to done
	task automatic op(input program_access_pkg::access_kind_t k, input logic bm, input logic [15:0] ea,
			input logic [15:0] wd, input logic ds, output int n);
		op_valid_i = 1'b1;
		kind_i = k;
		byte_mode_i = bm;
		ea_i = ea;
		wdata_i = wd;
		tick();
		op_valid_i = 1'b0;
		n = 1;
		chk("stall", 24'(!ds), 24'(stall_o));
		if (k != program_access_pkg::kind_data_read) begin
			chk("vis_active", 24'h0, 24'(visibility_active_o));
			chk("config_space", 24'(table_page_i[7]), 24'(config_space_o));
		end
		while (op_done_o !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		if (n >= 20) begin
			errors++;
			end_sim();
		end
		chk("data_space", 24'(ds), 24'(data_space_o));
		tick();
	endtask : op

	task automatic t_table_read();
		logic [15:0] ea, e, m;
		logic [23:0] w;
		int n;
		core_control_i = 16'h0004;
		for (int i = 0; i < 8; i++) begin
			table_page_i = {i[0], 7'h05};
			ea = 16'hC6A4 | 16'(i[0]);
			w = i_mem.word_at({table_page_i, ea[15:1], 1'b0});
			m = i[1] ? 16'h00FF : 16'hFFFF;
			if (!i[2]) begin
				e = i[1] ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w[15:0];
			end else begin
				e = (i[1] && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
			end
			op(i[2] ? program_access_pkg::kind_table_read_high : program_access_pkg::kind_table_read_low,
				i[1], ea, 16'h0000, 1'b0, n);
			chk("rdata", 24'(e & m), 24'(rdata_o & m));
			chk("pm_addr", {table_page_i, ea[15:1], 1'b0}, pm_addr_o);
			chk("read_cycles", 24'h2, 24'(n));
		end
	endtask : t_table_read

	task automatic t_window();
		logic [4:0] cfg [5] = '{5'b10001, 5'b00010, 5'b01110, 5'b01000, 5'b11110};
		logic [15:0] ea;
		logic [23:0] a, w;
		int n;
		core_control_i = 16'h0004;
		for (int i = 0; i < 5; i++) begin
			{is_move_i, in_repeat_i, repeat_edge_i} = cfg[i][4:2];
			visibility_page_i = 8'hA0 + 8'(i);
			ea = 16'h8000 | (16'h1234 << i);
			op(program_access_pkg::kind_data_read, 1'b0, ea, 16'h0000, 1'b0, n);
			a = {1'b0, visibility_page_i, ea[14:1], 1'b0};
			w = i_mem.word_at(a);
			chk("win_addr", a, pm_addr_o);
			chk("win_rdata", 24'(w[15:0]), 24'(rdata_o));
			chk("win_cycles", 24'(2 + cfg[i][1:0]), 24'(n));
		end
		core_control_i = 16'hFFFB;
		op(program_access_pkg::kind_data_read, 1'b0, 16'h9000, 16'h0000, 1'b1, n);
		chk("plain_cycles", 24'h1, 24'(n));
		core_control_i = 16'h0004;
		op(program_access_pkg::kind_data_read, 1'b0, 16'h7FFE, 16'h0000, 1'b1, n);
		chk("plain_cycles", 24'h1, 24'(n));
	endtask : t_window

	// buffer loaded in order within one 64-word group
	task automatic t_table_write();
		int n;
		table_page_i = 8'h03;
		op(program_access_pkg::kind_table_write_low, 1'b0, 16'h04D0, 16'h1234, 1'b0, n);
		chk("write_cycles", 24'h2, 24'(n));
		op(program_access_pkg::kind_table_write_high, 1'b0, 16'h04D0, 16'hFF77, 1'b0, n);
		op(program_access_pkg::kind_table_write_low, 1'b1, 16'h04D1, 16'h00AB, 1'b0, n);
		op(program_access_pkg::kind_table_write_high, 1'b1, 16'h04D1, 16'h0099, 1'b0, n);
		op(program_access_pkg::kind_table_write_low, 1'b0, 16'h04D2, 16'hBEEF, 1'b0, n);
		op(program_access_pkg::kind_table_write_high, 1'b1, 16'h04D2, 16'h00C5, 1'b0, n);
		chk("no_array_start", 24'h0, 24'(array_start_o));
		array_buf_idx_i = 6'h28;
		tick();
		chk("buf28", 24'h77AB34, array_buf_data_o);
		array_buf_idx_i = 6'h29;
		tick();
		chk("buf29", 24'hC5BEEF, array_buf_data_o);
	endtask : t_table_write

	task automatic start(input logic er, input logic [3:0] opc, input logic keys);
		erase_i = er;
		nvm_op_i = opc;
		write_enable_i = 1'b1;
		if (keys) begin
			key_wr_i = 1'b1;
			key_data_i = 8'h55;
			tick();
			key_data_i = 8'hAA;
			tick();
			key_wr_i = 1'b0;
		end
		wr_start_i = 1'b1;
		tick();
		wr_start_i = 1'b0;
	endtask : start

	task automatic t_flash();
		logic [3:0] opc [3] = '{4'h1, 4'h2, 4'h3};
		logic [23:0] msk [3] = '{program_access_pkg::ROW_ALIGN_MASK, program_access_pkg::PAGE_ALIGN_MASK,
			24'hFFFFFF};
		int n;
		for (int i = 0; i < 3; i++) begin
			start(i == 1, opc[i], 1'b1);
			chk("array_start", 24'h1, 24'(array_start_o));
			chk("busy", 24'h1, 24'(wr_busy_o));
			chk("cmd", 24'(i + 1), 24'(array_cmd_o));
			chk("array_addr", 24'h0304D2 & msk[i], array_addr_o);
			n = 0;
			while (wr_busy_o !== 1'b0 && n < 50) begin
				tick();
				n++;
			end
			if (n >= 50) begin
				errors++;
				end_sim();
			end
			chk("error", 24'h0, 24'(wr_error_o));
		end
		start(1'b0, 4'h1, 1'b0);
		chk("refused_start", 24'h0, 24'(array_start_o));
		chk("error", 24'h1, 24'(wr_error_o));
		err_clr_i = 1'b1;
		tick();
		err_clr_i = 1'b0;
		chk("error_clr", 24'h0, 24'(wr_error_o));
	endtask : t_flash

	initial begin
		repeat (4) @(posedge clk_i);
		#1;
		chk("ready_rst", 24'h1, 24'(op_ready_o));
		chk("busy_rst", 24'h0, 24'(wr_busy_o));
		rst_n_i = 1'b1;
		t_table_read();
		t_window();
		t_table_write();
		t_flash();
		end_sim();
	end
endmodule : program_space_data_access_bench
